//--- rtl/chained_math_function_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Four inputs, each with min, max, scaler
// - Normalise input to percent of span
// - Signed weight -1.0..1.0, default 1.0
// - Codes 0-5 are comparisons
// - Codes 6-8 are OR, AND, XOR
// - Codes 9-12 add, subtract, multiply, divide
// - Code 13 minimum, code 14 maximum
// - Stage one uses inputs 1 and 2
// - Stage two uses result and input 3
// - Stage three uses result and input 4
// - Unused input 2, 3 or 4 bypasses its stage
// - Logic operand true at 0.5 or above
// - Codes 0-8 give exactly 0 or 1
// - Erroneous input enters as zero
// - Arithmetic saturates at 0..100 percent, at -100..100 when negatives used
// - Divide by zero gives zero
// - Negative difference clamps unless negatives used
// - Map percent linearly onto output range
module chained_math_function_unit #(
   parameter int N = math_unit_pkg::N_IN
) (
   input  wire logic                 clock,
   input  wire logic                 nrst,
   input  wire logic [7:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 we,
   input  wire logic                 re,
   output logic      [31:0]          rdata,
   input  wire logic                 update,
   input  wire logic [N-1:0][15:0]   in_data,
   input  wire logic [N-1:0]         in_err,
   output logic      [15:0]          out_data,
   output logic      [17:0]          out_pct,
   output logic                      out_valid,
   output logic      [15:0]          out_min,
   output logic      [15:0]          out_max
);
   // ***************************
   // Stage operator
   // ***************************
   function automatic logic signed [17:0] stage_op(input logic [3:0] op,
                                                   input logic signed [17:0] a,
                                                   input logic signed [17:0] b,
                                                   input logic neg);
      logic signed [35:0] wide;
      logic signed [17:0] lo;
      logic signed [17:0] res;
      logic               ta;
      logic               tb;
      ta   = a >= math_unit_pkg::HALF;
      tb   = b >= math_unit_pkg::HALF;
      lo   = neg ? -math_unit_pkg::ONE : math_unit_pkg::ZERO;
      wide = 36'sh0;
      res  = math_unit_pkg::ZERO;
      case (op)
         math_unit_pkg::OP_EQ:  res = (a == b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_NE:  res = (a != b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_GT:  res = (a >  b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_GE:  res = (a >= b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_LT:  res = (a <  b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_LE:  res = (a <= b) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_OR:  res = (ta | tb) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_AND: res = (ta & tb) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_XOR: res = (ta ^ tb) ? math_unit_pkg::ONE : math_unit_pkg::ZERO;
         math_unit_pkg::OP_ADD: wide = 36'(a) + 36'(b);
         math_unit_pkg::OP_SUB: wide = 36'(a) - 36'(b);
         math_unit_pkg::OP_MUL: wide = (36'(a) * 36'(b)) >>> math_unit_pkg::FRAC;
         math_unit_pkg::OP_DIV: begin
            if (b == math_unit_pkg::ZERO) begin
               wide = 36'sh0;
            end else begin
               wide = (36'(a) <<< math_unit_pkg::FRAC) / 36'(b);
            end
         end
         math_unit_pkg::OP_MIN: wide = (a < b) ? 36'(a) : 36'(b);
         math_unit_pkg::OP_MAX: wide = (a > b) ? 36'(a) : 36'(b);
         default:               res = math_unit_pkg::ZERO;
      endcase
      if (op >= math_unit_pkg::OP_ADD && op <= math_unit_pkg::OP_MAX) begin
         // Saturate instead of wrapping: a wrapped percent would flip sign downstream
         if (wide > 36'(math_unit_pkg::ONE)) begin
            res = math_unit_pkg::ONE;
         end else if (wide < 36'(lo)) begin
            res = lo;
         end else begin
            res = wide[17:0];
         end
      end
      return res;
   endfunction

   // ***************************
   // Normalisation
   // ***************************
   // Span of zero or below reads as 0% rather than dividing by zero
   function automatic logic signed [17:0] norm(input logic signed [15:0] x,
                                               input logic signed [15:0] lo,
                                               input logic signed [15:0] hi);
      logic signed [32:0] num;
      logic signed [32:0] den;
      logic signed [32:0] q;
      logic signed [17:0] r;
      num = 33'(x) - 33'(lo);
      den = 33'(hi) - 33'(lo);
      q   = 33'sh0;
      if (den <= 33'sh0 || num <= 33'sh0) begin
         r = math_unit_pkg::ZERO;
      end else if (num >= den) begin
         r = math_unit_pkg::ONE;
      end else begin
         q = (num <<< math_unit_pkg::FRAC) / den;
         r = q[17:0];
      end
      return r;
   endfunction

   // ***************************
   // State
   // ***************************
   logic signed [15:0] min_r [N];
   logic signed [15:0] max_r [N];
   logic signed [15:0] scl_r [N];
   logic        [N-1:0] used_r;
   logic        [3:0]  op_r  [3];
   logic signed [15:0] omin_r;
   logic signed [15:0] omax_r;
   logic signed [15:0] cap_r [N];
   logic        [N-1:0] caperr_r;
   logic               pending_r;
   logic        [15:0] out_data_r;
   logic        [17:0] out_pct_r;
   logic               out_valid_r;
   logic        [31:0] rdata_r;
   logic        [31:0] rdata_nxt;

   // ***************************
   // Register decode
   // ***************************
   wire logic        in_region = (addr[7:6] == 2'b00);
   wire logic [1:0]  idx       = addr[5:4];
   wire logic [7:0]  fld       = {4'h0, addr[3:0]};
   wire logic        wr_in     = we && in_region;
   wire logic signed [15:0] wr_h = wdata[15:0];
   // Scaler writes are clamped so the weight never leaves -1.0..1.0
   wire logic signed [15:0] scl_w = (wr_h > math_unit_pkg::SCL_MAX) ? math_unit_pkg::SCL_MAX :
                                    (wr_h < math_unit_pkg::SCL_MIN) ? math_unit_pkg::SCL_MIN : wr_h;

   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < N; i++) begin
            min_r[i] <= math_unit_pkg::IN_MIN_RST;
            max_r[i] <= math_unit_pkg::IN_MAX_RST;
            scl_r[i] <= math_unit_pkg::IN_SCL_RST;
         end
         for (int i = 0; i < 3; i++) begin
            op_r[i] <= math_unit_pkg::OP_RST;
         end
         used_r <= {N{math_unit_pkg::IN_SRC_RST}};
         omin_r <= math_unit_pkg::OMIN_RST;
         omax_r <= math_unit_pkg::OMAX_RST;
      end else if (wr_in) begin
         case (fld)
            math_unit_pkg::IN_MIN_OFS: min_r[idx] <= wr_h;
            math_unit_pkg::IN_MAX_OFS: max_r[idx] <= wr_h;
            math_unit_pkg::IN_SCL_OFS: scl_r[idx] <= scl_w;
            math_unit_pkg::IN_SRC_OFS: used_r[idx] <= wdata[0];
            default: ;
         endcase
      end else if (we) begin
         case (addr)
            math_unit_pkg::OP1_ADDR:  op_r[0] <= wdata[3:0];
            math_unit_pkg::OP2_ADDR:  op_r[1] <= wdata[3:0];
            math_unit_pkg::OP3_ADDR:  op_r[2] <= wdata[3:0];
            math_unit_pkg::OMIN_ADDR: omin_r  <= wr_h;
            math_unit_pkg::OMAX_ADDR: omax_r  <= wr_h;
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata_nxt = 32'h0;
      if (in_region) begin
         case (fld)
            math_unit_pkg::IN_MIN_OFS: rdata_nxt = {16'h0, min_r[idx]};
            math_unit_pkg::IN_MAX_OFS: rdata_nxt = {16'h0, max_r[idx]};
            math_unit_pkg::IN_SCL_OFS: rdata_nxt = {16'h0, scl_r[idx]};
            math_unit_pkg::IN_SRC_OFS: rdata_nxt = {31'h0, used_r[idx]};
            default:                   rdata_nxt = 32'h0;
         endcase
      end else begin
         case (addr)
            math_unit_pkg::OP1_ADDR:  rdata_nxt = {28'h0, op_r[0]};
            math_unit_pkg::OP2_ADDR:  rdata_nxt = {28'h0, op_r[1]};
            math_unit_pkg::OP3_ADDR:  rdata_nxt = {28'h0, op_r[2]};
            math_unit_pkg::OMIN_ADDR: rdata_nxt = {16'h0, omin_r};
            math_unit_pkg::OMAX_ADDR: rdata_nxt = {16'h0, omax_r};
            math_unit_pkg::RES_ADDR:  rdata_nxt = {16'h0, out_data_r};
            math_unit_pkg::PCT_ADDR:  rdata_nxt = {14'h0, out_pct_r};
            default:                  rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         rdata_r <= 32'h0;
      end else begin
         rdata_r <= re ? rdata_nxt : 32'h0;
      end
   end

   // ***************************
   // Input scaling
   // ***************************
   logic signed [17:0] s_w [N];
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_in
         wire logic signed [17:0] n_w = norm(cap_r[g], min_r[g], max_r[g]);
         wire logic signed [35:0] p_w = (36'(n_w) * 36'(scl_r[g])) >>> math_unit_pkg::FRAC;
         assign s_w[g] = (caperr_r[g] || !used_r[g]) ? math_unit_pkg::ZERO : p_w[17:0];
      end
   endgenerate

   // ***************************
   // Stage chain
   // ***************************
   // Negative results are only allowed when a used input carries a negative weight
   logic [N-1:0] negw;
   always_comb begin
      for (int i = 0; i < N; i++) begin
         negw[i] = used_r[i] & scl_r[i][15];
      end
   end
   wire logic neg_ok = |negw;
   wire logic signed [17:0] r1_w = used_r[1] ? stage_op(op_r[0], s_w[0], s_w[1], neg_ok) : s_w[0];
   wire logic signed [17:0] r2_w = used_r[2] ? stage_op(op_r[1], r1_w, s_w[2], neg_ok) : r1_w;
   wire logic signed [17:0] r3_w = used_r[3] ? stage_op(op_r[2], r2_w, s_w[3], neg_ok) : r2_w;
   wire logic signed [17:0] fin_w = (r3_w < math_unit_pkg::ZERO) ? math_unit_pkg::ZERO :
                                    (r3_w > math_unit_pkg::ONE) ? math_unit_pkg::ONE : r3_w;
   wire logic signed [16:0] span_w = 17'(omax_r) - 17'(omin_r);
   wire logic signed [35:0] map_w  = 36'(omin_r) + ((36'(fin_w) * 36'(span_w)) >>> math_unit_pkg::FRAC);

   // ***************************
   // Update step
   // ***************************
   always_ff @(posedge clock) begin
      if (!nrst) begin
         for (int i = 0; i < N; i++) begin
            cap_r[i] <= 16'sh0;
         end
         caperr_r    <= '0;
         pending_r   <= 1'b0;
         out_data_r  <= 16'h0;
         out_pct_r   <= 18'h0;
         out_valid_r <= 1'b0;
      end else begin
         if (update) begin
            for (int i = 0; i < N; i++) begin
               cap_r[i] <= in_data[i];
            end
            caperr_r <= in_err;
         end
         pending_r   <= update;
         out_valid_r <= pending_r;
         if (pending_r) begin
            out_data_r <= map_w[15:0];
            out_pct_r  <= fin_w;
         end
      end
   end

   assign rdata     = rdata_r;
   assign out_data  = out_data_r;
   assign out_pct   = out_pct_r;
   assign out_valid = out_valid_r;
   assign out_min   = omin_r;
   assign out_max   = omax_r;

   // ***************************
   // Assertions
   // ***************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);

   sequence s_eval;
      ##1 pending_r ##1 out_valid;
   endsequence

   a_update_done: assert property (update |-> s_eval)
      else $error("update did not give out_valid two cycles later");
   a_out_hold: assert property (!out_valid |-> $stable(out_data))
      else $error("out_data changed without out_valid");
   a_pct_range: assert property (out_valid |-> out_pct <= 18'(math_unit_pkg::ONE))
      else $error("output percent above full scale");
   a_logic_binary: assert property (used_r[1] && op_r[0] <= math_unit_pkg::OP_XOR
                                    |-> (r1_w == math_unit_pkg::ZERO || r1_w == math_unit_pkg::ONE))
      else $error("logic stage result not 0 or 1");
   a_div_zero: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_DIV && s_w[1] == 0
                                |-> r1_w == math_unit_pkg::ZERO)
      else $error("divide by zero not zero");
   a_sub_clamp: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_SUB && !neg_ok
                                 |-> r1_w >= math_unit_pkg::ZERO)
      else $error("negative difference not clamped");
   a_or_thresh: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_OR
                                 && s_w[0] >= math_unit_pkg::HALF |-> r1_w == math_unit_pkg::ONE)
      else $error("OR missed operand at 0.5");
   a_stage_bypass: assert property (!used_r[3] |-> r3_w == r2_w)
      else $error("unused input 4 did not bypass stage 3");
   a_stage1_skip: assert property (!used_r[1] |-> r1_w == s_w[0])
      else $error("unused input 2 did not bypass stage 1");
   a_err_zero: assert property (caperr_r[0] |-> s_w[0] == math_unit_pkg::ZERO)
      else $error("erroneous input not zero");
   a_map_low: assert property (pending_r && fin_w == math_unit_pkg::ZERO |=> out_data == $past(omin_r))
      else $error("0 percent not mapped to output minimum");
   a_map_high: assert property (pending_r && fin_w == math_unit_pkg::ONE |=> out_data == $past(omax_r))
      else $error("100 percent not mapped to output maximum");
   a_cmp_less: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_LT
                                |-> r1_w == ((s_w[0] < s_w[1]) ? math_unit_pkg::ONE : math_unit_pkg::ZERO))
      else $error("less-than stage result wrong");
   a_xor_both: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_XOR
                                && s_w[0] >= math_unit_pkg::HALF && s_w[1] >= math_unit_pkg::HALF
                                |-> r1_w == math_unit_pkg::ZERO)
      else $error("XOR true with both operands true");
   a_add_sum: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_ADD && !neg_ok
                               && s_w[0] + s_w[1] <= math_unit_pkg::ONE |-> r1_w == s_w[0] + s_w[1])
      else $error("sum below full scale altered");
   a_min_pick: assert property (used_r[1] && op_r[0] == math_unit_pkg::OP_MIN
                                |-> r1_w == ((s_w[0] < s_w[1]) ? s_w[0] : s_w[1]))
      else $error("minimum stage picked wrong operand");
   a_stage2_max: assert property (used_r[2] && op_r[1] == math_unit_pkg::OP_MAX
                                  |-> r2_w == ((r1_w > s_w[2]) ? r1_w : s_w[2]))
      else $error("stage 2 maximum used wrong operands");
   a_stage3_min: assert property (used_r[3] && op_r[2] == math_unit_pkg::OP_MIN
                                  |-> r3_w == ((r2_w < s_w[3]) ? r2_w : s_w[3]))
      else $error("stage 3 minimum used wrong operands");
endmodule
`default_nettype wire

//--- rtl/math_unit_pkg.sv
`default_nettype none
package math_unit_pkg;
   // ***************************
   // Number format
   // ***************************
   // Percent values are signed Q4.14: 1.0 (100%) = 16384
   localparam int                 DW      = 16;
   localparam int                 PW      = 18;
   localparam int                 FRAC    = 14;
   localparam int                 N_IN    = 4;
   localparam logic signed [17:0] ONE     = 18'sh04000;
   localparam logic signed [17:0] HALF    = 18'sh02000;
   localparam logic signed [17:0] ZERO    = 18'sh00000;
   localparam logic signed [15:0] SCL_MAX = 16'sh4000;
   localparam logic signed [15:0] SCL_MIN = 16'shc000;

   // ***************************
   // Register map
   // ***************************
   localparam logic [7:0] IN_MIN_OFS = 8'h00;
   localparam logic [7:0] IN_MAX_OFS = 8'h04;
   localparam logic [7:0] IN_SCL_OFS = 8'h08;
   localparam logic [7:0] IN_SRC_OFS = 8'h0c;
   localparam logic [7:0] OP1_ADDR   = 8'h40;
   localparam logic [7:0] OP2_ADDR   = 8'h44;
   localparam logic [7:0] OP3_ADDR   = 8'h48;
   localparam logic [7:0] OMIN_ADDR  = 8'h4c;
   localparam logic [7:0] OMAX_ADDR  = 8'h50;
   localparam logic [7:0] RES_ADDR   = 8'h54;
   localparam logic [7:0] PCT_ADDR   = 8'h58;

   // ***************************
   // Reset values
   // ***************************
   localparam logic [15:0] IN_MIN_RST = 16'h0000;
   localparam logic [15:0] IN_MAX_RST = 16'h03e8;
   localparam logic [15:0] IN_SCL_RST = 16'h4000;
   localparam logic        IN_SRC_RST = 1'b0;
   localparam logic [3:0]  OP_RST     = 4'h9;
   localparam logic [15:0] OMIN_RST   = 16'h0000;
   localparam logic [15:0] OMAX_RST   = 16'h03e8;

   // ***************************
   // Operator codes
   // ***************************
   localparam logic [3:0] OP_EQ  = 4'h0;
   localparam logic [3:0] OP_NE  = 4'h1;
   localparam logic [3:0] OP_GT  = 4'h2;
   localparam logic [3:0] OP_GE  = 4'h3;
   localparam logic [3:0] OP_LT  = 4'h4;
   localparam logic [3:0] OP_LE  = 4'h5;
   localparam logic [3:0] OP_OR  = 4'h6;
   localparam logic [3:0] OP_AND = 4'h7;
   localparam logic [3:0] OP_XOR = 4'h8;
   localparam logic [3:0] OP_ADD = 4'h9;
   localparam logic [3:0] OP_SUB = 4'ha;
   localparam logic [3:0] OP_MUL = 4'hb;
   localparam logic [3:0] OP_DIV = 4'hc;
   localparam logic [3:0] OP_MIN = 4'hd;
   localparam logic [3:0] OP_MAX = 4'he;
endpackage
`default_nettype wire

//--- testbench/chained_math_function_unit_test.sv
`timescale 1ns/1ps
`default_nettype none
module chained_math_function_unit_test;
   logic             clock;
   logic             nrst;
   logic [7:0]       addr;
   logic [31:0]      wdata;
   logic             we;
   logic             re;
   logic [31:0]      rdata;
   logic             update;
   logic [3:0][15:0] in_data;
   logic [3:0]       in_err;
   logic [15:0]      out_data;
   logic [17:0]      out_pct;
   logic             out_valid;
   logic [15:0]      out_min;
   logic [15:0]      out_max;
   logic [31:0]      rnd;
   int               seen_pct;
   int               n_mismatch;
   int               checks;
   int               cycles;
   int               mn[4];
   int               mx[4];
   int               sc[4];
   int               xin[4];
   int               op[3];
   int               omin;
   int               omax;
   int               ep;
   int               ep2;
   bit               used[4];
   bit               xerr[4];

   chained_math_function_unit #(.N(4)) dut (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
      .we(we), .re(re), .rdata(rdata), .update(update), .in_data(in_data), .in_err(in_err),
      .out_data(out_data), .out_pct(out_pct), .out_valid(out_valid), .out_min(out_min), .out_max(out_max));
   output_consumer sink (.clock(clock), .nrst(nrst), .out_valid(out_valid), .out_data(out_data),
      .out_min(out_min), .out_max(out_max), .seen_pct(seen_pct));

   always #2.5 clock = ~clock;
   // Whole run needs about 3100 cycles; the ceiling leaves margin
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end

   // ***************************
   // Reference model
   // ***************************
   function automatic logic [31:0] nr();
      for (int i = 0; i < 8; i++) begin
         rnd = {rnd[30:0], rnd[31] ^ rnd[21] ^ rnd[1] ^ rnd[0]};
      end
      return rnd;
   endfunction
   function automatic int clip(int v, int lo, int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   function automatic int tf(bit t);
      return t ? 16384 : 0;
   endfunction
   function automatic int stage(int c, int a, int b, int lo);
      bit ta;
      bit tb;
      ta = a >= 8192;
      tb = b >= 8192;
      case (c)
         0: return tf(a == b);
         1: return tf(a != b);
         2: return tf(a > b);
         3: return tf(a >= b);
         4: return tf(a < b);
         5: return tf(a <= b);
         6: return tf(ta || tb);
         7: return tf(ta && tb);
         8: return tf(ta ^ tb);
         9: return clip(a + b, lo, 16384);
         10: return clip(a - b, lo, 16384);
         11: return clip((a * b) >>> 14, lo, 16384);
         12: return (b == 0) ? 0 : clip((a * 16384) / b, lo, 16384);
         13: return clip((a < b) ? a : b, lo, 16384);
         14: return clip((a > b) ? a : b, lo, 16384);
         default: return 0;
      endcase
   endfunction
   function automatic int exp_pct();
      int s[4];
      int n;
      int lo;
      int r;
      lo = 0;
      for (int i = 0; i < 4; i++) begin
         n = (mx[i] <= mn[i]) ? 0 : ((xin[i] - mn[i]) * 16384) / (mx[i] - mn[i]);
         s[i] = (!used[i] || xerr[i]) ? 0 : (clip(n, 0, 16384) * sc[i]) >>> 14;
         if (used[i] && sc[i] < 0) begin
            lo = -16384;
         end
      end
      r = s[0];
      for (int k = 1; k < 4; k++) begin
         if (used[k]) begin
            r = stage(op[k-1], r, s[k], lo);
         end
      end
      return clip(r, 0, 16384);
   endfunction
   function automatic int eout(int p);
      return omin + ((p * (omax - omin)) >>> 14);
   endfunction
   function automatic bit near(int a, int b);
      if (omax <= omin) begin
         return a == 0;
      end
      return (a - b <= 16384 / (omax - omin) + 2) && (b - a <= 16384 / (omax - omin) + 2);
   endfunction

   // ***************************
   // Bus and checking tasks
   // ***************************
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      we    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clock);
      we <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      re   <= 1'b1;
      addr <= a;
      @(posedge clock);
      re <= 1'b0;
      #1;
      chk(rdata, e);
      @(posedge clock);
      #1;
      chk(rdata, 32'h0);
   endtask
   task automatic cfg_in(input int i, input int lo, input int hi, input logic [15:0] s, input bit u);
      logic [7:0] b;
      b = 8'(16 * i);
      mn[i] = int'($signed(16'(lo)));
      mx[i] = int'($signed(16'(hi)));
      sc[i] = clip(int'($signed(s)), -16384, 16384);
      used[i] = u;
      wr(b + math_unit_pkg::IN_MIN_OFS, 32'(16'(lo)));
      wr(b + math_unit_pkg::IN_MAX_OFS, 32'(16'(hi)));
      wr(b + math_unit_pkg::IN_SCL_OFS, 32'(s));
      wr(b + math_unit_pkg::IN_SRC_OFS, 32'(u));
      rd(b + math_unit_pkg::IN_SCL_OFS, {16'h0, 16'(sc[i])});
   endtask
   task automatic set_op(input int k, input int c);
      op[k] = c;
      wr(math_unit_pkg::OP1_ADDR + 8'(4 * k), 32'(c));
   endtask
   task automatic set_out(input int lo, input int hi);
      omin = int'($signed(16'(lo)));
      omax = int'($signed(16'(hi)));
      wr(math_unit_pkg::OMIN_ADDR, 32'(16'(lo)));
      wr(math_unit_pkg::OMAX_ADDR, 32'(16'(hi)));
      #1;
      chk(32'({out_min, out_max}), {16'(omin), 16'(omax)});
   endtask
   task automatic drive_in();
      for (int i = 0; i < 4; i++) begin
         in_data[i] <= 16'(xin[i]);
         in_err[i]  <= xerr[i];
      end
   endtask
   task automatic run();
      @(posedge clock);
      update <= 1'b1;
      drive_in();
      ep = exp_pct();
      @(posedge clock);
      update <= 1'b0;
      #1;
      chk(32'(out_valid), 32'h0);
      @(posedge clock);
      #1;
      chk(32'(out_valid), 32'h1);
      chk(32'(out_pct), 32'(ep[17:0]));
      chk(32'(out_data), {16'h0, 16'(eout(ep))});
      @(posedge clock);
      #1;
      chk(32'(out_valid), 32'h0);
      chk(32'(near(seen_pct, ep)), 32'h1);
   endtask
   task automatic finish_test();
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      int lo;
      clock = 0;
      nrst = 0;
      we = 0;
      re = 0;
      addr = 0;
      wdata = 0;
      update = 0;
      in_data = '0;
      in_err = '0;
      rnd = 32'd71723;
      n_mismatch = 0;
      checks = 0;
      cycles = 0;
      omin = 0;
      omax = 1000;
      for (int i = 0; i < 4; i++) begin
         mn[i] = 0;
         mx[i] = 1000;
         sc[i] = 16384;
         used[i] = 0;
         xerr[i] = 0;
         xin[i] = 0;
      end
      for (int k = 0; k < 3; k++) begin
         op[k] = 9;
      end
      repeat (6) @(posedge clock);
      nrst <= 1'b1;
      @(posedge clock);
      #1;
      chk({out_max, out_min}, 32'h03e80000);
      for (int i = 0; i < 4; i++) begin
         rd(8'(16 * i), 32'h0);
         rd(8'(16 * i + 4), 32'h3e8);
         rd(8'(16 * i + 8), 32'h4000);
         rd(8'(16 * i + 12), 32'h0);
      end
      for (int k = 0; k < 3; k++) begin
         rd(math_unit_pkg::OP1_ADDR + 8'(4 * k), 32'h9);
      end
      wr(8'h5c, 32'h1234);
      rd(8'h5c, 32'h0);
      run();
      // Every operator code on the first stage, with equal, zero and threshold operands
      cfg_in(0, 0, 1000, 16'h4000, 1'b1);
      cfg_in(1, 0, 1000, 16'h4000, 1'b1);
      for (int c = 0; c < 16; c++) begin
         set_op(0, c);
         rd(math_unit_pkg::OP1_ADDR, 32'(c));
         for (int k = 0; k < 6; k++) begin
            xin[0] = (k == 2) ? 500 : int'(nr() % 1100) - 50;
            xin[1] = (k == 0 || k == 2) ? xin[0] : ((k == 1) ? 0 : int'(nr() % 1100) - 50);
            xerr[1] = k == 3;
            run();
         end
      end
      // Two updates back to back give two results back to back
      set_op(0, 9);
      xerr[1] = 0;
      xin[1] = 300;
      @(posedge clock);
      update <= 1'b1;
      drive_in();
      ep = exp_pct();
      xin[1] = 700;
      ep2 = exp_pct();
      @(posedge clock);
      drive_in();
      @(posedge clock);
      update <= 1'b0;
      #1;
      chk({13'h0, out_valid, out_pct}, {13'h0, 1'b1, ep[17:0]});
      @(posedge clock);
      #1;
      chk({13'h0, out_valid, out_pct}, {13'h0, 1'b1, ep2[17:0]});
      // Random chains with bypasses, errors and negative weights
      repeat (40) begin
         for (int i = 0; i < 4; i++) begin
            lo = int'(nr() % 2000) - 1000;
            cfg_in(i, lo, lo + int'(nr() % 3000) - 200, 16'(int'(nr() % 40000) - 20000), (nr() % 4) != 0);
            xin[i] = mn[i] + int'(nr() % 3000) - 100;
            xerr[i] = (nr() % 6) == 0;
         end
         for (int k = 0; k < 3; k++) begin
            set_op(k, int'(nr() % 16));
         end
         set_out(int'(nr() % 4000) - 2000, int'(nr() % 4000) - 1000);
         run();
         rd(math_unit_pkg::RES_ADDR, {16'h0, 16'(eout(ep))});
         rd(math_unit_pkg::PCT_ADDR, {14'h0, ep[17:0]});
      end
      finish_test();
   end
endmodule
`default_nettype wire

//--- testbench/output_consumer.sv
`timescale 1ns/1ps
`default_nettype none
module output_consumer (
   input  wire logic        clock,
   input  wire logic        nrst,
   input  wire logic        out_valid,
   input  wire logic [15:0] out_data,
   input  wire logic [15:0] out_min,
   input  wire logic [15:0] out_max,
   output var  int          seen_pct
);
   // ***************************
   // Consumer reading
   // ***************************
   int span_w;
   int ofs_w;
   // Limits come from the unit's published range, never from local setup
   assign span_w = int'($signed(out_max)) - int'($signed(out_min));
   assign ofs_w  = int'($signed(out_data)) - int'($signed(out_min));
   always_ff @(posedge clock) begin
      if (!nrst) begin
         seen_pct <= 0;
      end else if (out_valid) begin
         seen_pct <= (span_w > 0) ? (ofs_w * 16384) / span_w : 0;
      end
   end
endmodule
`default_nettype wire
